/* rtl/pds_synth_ctrl.sv */
// Purpose: divider, detector and serial load logic of an integer-N synthesizer
// Assumes: all pins are sampled on i_clk and are slower than half its rate
// Notes:   the rf pin stands for the prescaler input at a rate i_clk can sample
// What this block does
// - serial bit shifted on each clock rise
// - msb first, last bit lands lowest
// - load strobe rise fills one latch
// - select 0 feedback latch, 1 reference
// - word bits 17..1 data, bit 0 select
// - reference latch fields, bit 12 spare zero
// - feedback latch main, swallow, power fields
// - 10-bit reference divider, ratio 2..1023
// - 15-bit feedback divider, swallow plus main
// - 32/33 prescaler, swallow counter picks modulus
// - modulus plus one for swallow cycles
// - detector compares divided pulses, issues commands
// - sense bit picks command for lagging feedback
// - pump feedback overlap removes dead zone
// - pump drives high, low, else floats
// - diagnostic and float bits both set put divider on pump pin
// - chip enable low powers down, floats pump
// - sleep stops counters, floats rf, oscillator off
// - power down floats pump and comparator
// - counter clear resets both, restart aligned
// - serial loading works in all power modes
// - power field selects run, sleep, clear, off
`include "pds_params.svh"

module pds_synth_ctrl
    import pds_pkg::*;
(
    input  wire logic                  i_clk,
    input  wire logic                  i_rst_n,
    input  wire logic                  i_sclk,
    input  wire logic                  i_sdata,
    input  wire logic                  i_load_strobe,
    input  wire logic                  i_chip_en,
    input  wire logic                  i_ref_clock_pin,
    input  wire logic                  i_rf_pin,
    output logic                       o_cp_out,
    output logic                       o_cp_oe_n,
    output logic                       o_pump_up,
    output logic                       o_pump_dn,
    output logic                       o_divided_ref_pulse,
    output logic                       o_divided_rf_pulse,
    output logic                       o_rf_in_float,
    output logic                       o_ref_osc_pd,
    output logic [`PDS_REF_W-1:0]      o_ref_latch,
    output logic [`PDS_FB_W-1:0]       o_fb_latch
);

    // =================================================================
    // pin synchronisers
    logic [`PDS_PIN_W-1:0] pin_s1_q;
    logic [`PDS_PIN_W-1:0] pin_s2_q;
    logic [`PDS_PIN_W-1:0] pin_s3_q;
    logic [`PDS_PIN_W-1:0] pin_rise;

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            pin_s1_q <= '0;
            pin_s2_q <= '0;
            pin_s3_q <= '0;
        end else begin
            pin_s1_q <= {i_rf_pin, i_ref_clock_pin, i_chip_en, i_load_strobe, i_sdata, i_sclk};
            pin_s2_q <= pin_s1_q;
            pin_s3_q <= pin_s2_q;
        end
    end

    assign pin_rise = pin_s2_q & ~pin_s3_q;

    // =================================================================
    // serial shift register and latches
    logic [`PDS_SR_W-1:0]  shift_q;
    logic [`PDS_SR_W-1:0]  shift_d;
    logic [`PDS_REF_W-1:0] ref_latch_q;
    logic [`PDS_REF_W-1:0] ref_latch_d;
    logic [`PDS_FB_W-1:0]  fb_latch_q;
    logic [`PDS_FB_W-1:0]  fb_latch_d;

    // no power state gates this group, so loading never stops
    always_comb begin
        shift_d     = shift_q;
        ref_latch_d = ref_latch_q;
        fb_latch_d  = fb_latch_q;
        if (pin_rise[`PDS_PIN_SCLK]) begin
            shift_d = {shift_q[`PDS_SR_W-2:0], pin_s2_q[`PDS_PIN_SDATA]};
        end
        if (pin_rise[`PDS_PIN_LOAD]) begin
            if (shift_q[`PDS_SEL_BIT]) begin
                ref_latch_d = shift_q[`PDS_REF_W:`PDS_DATA_LO];
            end else begin
                fb_latch_d = shift_q[`PDS_DATA_HI:`PDS_DATA_LO];
            end
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            shift_q     <= '0;
            ref_latch_q <= `PDS_REF_RESET;
            fb_latch_q  <= `PDS_FB_RESET;
        end else begin
            shift_q     <= shift_d;
            ref_latch_q <= ref_latch_d;
            fb_latch_q  <= fb_latch_d;
        end
    end

    // =================================================================
    // latch fields
    logic [9:0] ref_div_value;
    logic       pump_float_bit;
    logic       detector_sense_bit;
    logic       diag_bit;
    logic [9:0] main_div_value;
    logic [4:0] swallow_count_value;
    logic [1:0] power_ctrl_field;
    logic       divider_clear_bit;
    logic       sleep_bit;

    assign ref_div_value       = ref_latch_q[`PDS_REF_DIV_HI:`PDS_REF_DIV_LO];
    assign pump_float_bit      = ref_latch_q[`PDS_REF_FLOAT];
    assign detector_sense_bit  = ref_latch_q[`PDS_REF_SENSE];
    assign diag_bit            = ref_latch_q[`PDS_REF_DIAG];
    assign main_div_value      = fb_latch_q[`PDS_FB_MAIN_HI:`PDS_FB_MAIN_LO];
    assign swallow_count_value = fb_latch_q[`PDS_FB_SWAL_HI:`PDS_FB_SWAL_LO];
    assign power_ctrl_field    = fb_latch_q[`PDS_FB_CLEAR:`PDS_FB_SLEEP];
    assign divider_clear_bit   = power_ctrl_field[1];
    assign sleep_bit           = power_ctrl_field[0];

    // =================================================================
    // power control
    pds_power_t power_q;
    pds_power_t power_d;
    logic       up_q;
    logic       dn_q;
    logic       hold;

    always_comb begin
        power_d = PDS_RUN;
        if (!pin_s2_q[`PDS_PIN_CE]) begin
            power_d = PDS_DOWN;
        end else if (divider_clear_bit && sleep_bit) begin
            power_d = PDS_DOWN;
        end else if (divider_clear_bit) begin
            power_d = PDS_CLEAR;
        end else if (sleep_bit) begin
            // synchronous sleep waits for the current pump pulse to finish
            unique case (power_q)
                PDS_RUN,
                PDS_SLEEP_WAIT: power_d = (up_q || dn_q) ? PDS_SLEEP_WAIT : PDS_DOWN;
                PDS_DOWN,
                PDS_CLEAR:      power_d = PDS_DOWN;
            endcase
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            power_q <= PDS_DOWN;
        end else begin
            power_q <= power_d;
        end
    end

    // counters sit at zero together, so both restart on the same edge
    assign hold          = (power_q == PDS_DOWN) || (power_q == PDS_CLEAR);
    assign o_rf_in_float = (power_q == PDS_DOWN);
    assign o_ref_osc_pd  = (power_q == PDS_DOWN);

    // =================================================================
    // reference divider and pulse-swallow feedback divider
    logic [9:0]            ref_cnt_q;
    logic [9:0]            ref_cnt_d;
    logic                  ref_pulse_q;
    logic                  ref_pulse_d;
    logic [`PDS_PRE_W-1:0] pre_cnt_q;
    logic [`PDS_PRE_W-1:0] pre_cnt_d;
    logic [4:0]            swal_cnt_q;
    logic [4:0]            swal_cnt_d;
    logic [9:0]            main_cnt_q;
    logic [9:0]            main_cnt_d;
    logic                  fb_pulse_q;
    logic                  fb_pulse_d;
    logic                  swallowing;
    logic [`PDS_PRE_W-1:0] pre_last;
    logic                  pre_out;

    assign swallowing = (swal_cnt_q < swallow_count_value);
    assign pre_last   = swallowing ? `PDS_PRE_HIGH_LAST : `PDS_PRE_LOW_LAST;
    assign pre_out    = pin_rise[`PDS_PIN_RF] && (pre_cnt_q == pre_last);

    always_comb begin
        ref_cnt_d   = ref_cnt_q;
        ref_pulse_d = 1'b0;
        pre_cnt_d   = pre_cnt_q;
        swal_cnt_d  = swal_cnt_q;
        main_cnt_d  = main_cnt_q;
        fb_pulse_d  = 1'b0;
        if (hold) begin
            ref_cnt_d  = '0;
            pre_cnt_d  = '0;
            swal_cnt_d = '0;
            main_cnt_d = '0;
        end else begin
            if (pin_rise[`PDS_PIN_REF]) begin
                if (ref_cnt_q == ref_div_value - 10'h001) begin
                    ref_cnt_d   = '0;
                    ref_pulse_d = 1'b1;
                end else begin
                    ref_cnt_d = ref_cnt_q + 10'h001;
                end
            end
            if (pin_rise[`PDS_PIN_RF]) begin
                pre_cnt_d = pre_out ? '0 : pre_cnt_q + 6'h01;
            end
            if (pre_out) begin
                if (main_cnt_q == main_div_value - 10'h001) begin
                    main_cnt_d = '0;
                    swal_cnt_d = '0;
                    fb_pulse_d = 1'b1;
                end else begin
                    main_cnt_d = main_cnt_q + 10'h001;
                    if (swallowing) begin
                        swal_cnt_d = swal_cnt_q + 5'h01;
                    end
                end
            end
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            ref_cnt_q   <= '0;
            ref_pulse_q <= 1'b0;
            pre_cnt_q   <= '0;
            swal_cnt_q  <= '0;
            main_cnt_q  <= '0;
            fb_pulse_q  <= 1'b0;
        end else begin
            ref_cnt_q   <= ref_cnt_d;
            ref_pulse_q <= ref_pulse_d;
            pre_cnt_q   <= pre_cnt_d;
            swal_cnt_q  <= swal_cnt_d;
            main_cnt_q  <= main_cnt_d;
            fb_pulse_q  <= fb_pulse_d;
        end
    end

    // =================================================================
    // phase/frequency detector and pump
    logic up_d;
    logic dn_d;
    logic up_cmd;
    logic dn_cmd;
    logic cp_out_q;
    logic cp_out_d;
    logic cp_oe_n_q;
    logic cp_oe_n_d;

    // up_q means reference leads, dn_q means feedback leads
    always_comb begin
        up_d = up_q || ref_pulse_q;
        dn_d = dn_q || fb_pulse_q;
        // both high for one cycle before clearing: the pump overlap
        // keeps tiny phase errors from falling into a dead zone
        if (up_q && dn_q) begin
            up_d = ref_pulse_q;
            dn_d = fb_pulse_q;
        end
        if (hold) begin
            up_d = 1'b0;
            dn_d = 1'b0;
        end
    end

    assign up_cmd = detector_sense_bit ? up_q : dn_q;
    assign dn_cmd = detector_sense_bit ? dn_q : up_q;

    always_comb begin
        cp_out_d  = 1'b0;
        cp_oe_n_d = 1'b1;
        if (power_q == PDS_DOWN) begin
            cp_oe_n_d = 1'b1;
        end else if (diag_bit && pump_float_bit) begin
            cp_oe_n_d = 1'b0;
            cp_out_d  = detector_sense_bit ? fb_pulse_q : ref_pulse_q;
        end else if (!pump_float_bit && (up_cmd != dn_cmd)) begin
            cp_oe_n_d = 1'b0;
            cp_out_d  = up_cmd;
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            up_q      <= 1'b0;
            dn_q      <= 1'b0;
            cp_out_q  <= 1'b0;
            cp_oe_n_q <= 1'b1;
        end else begin
            up_q      <= up_d;
            dn_q      <= dn_d;
            cp_out_q  <= cp_out_d;
            cp_oe_n_q <= cp_oe_n_d;
        end
    end

    // =================================================================
    // outputs
    assign o_cp_out            = cp_out_q;
    assign o_cp_oe_n           = cp_oe_n_q;
    assign o_pump_up           = up_cmd;
    assign o_pump_dn           = dn_cmd;
    assign o_divided_ref_pulse = ref_pulse_q;
    assign o_divided_rf_pulse  = fb_pulse_q;
    assign o_ref_latch         = ref_latch_q;
    assign o_fb_latch          = fb_latch_q;

endmodule : pds_synth_ctrl

/* rtl/pds_params.svh */
// Purpose: constants for the synthesizer divider control block
// Assumes: included by its bare name
// Notes:   field positions refer to latch bits, not shift register bits
`ifndef PDS_PARAMS_SVH
`define PDS_PARAMS_SVH

// =====================================================================
// serial word
`define PDS_SR_W          18
`define PDS_SEL_BIT       0
`define PDS_DATA_HI       17
`define PDS_DATA_LO       1

// =====================================================================
// reference latch, bits 14..1 of the word stored as latch bits 13..0
`define PDS_REF_W         14
`define PDS_REF_DIV_HI    9
`define PDS_REF_DIV_LO    0
`define PDS_REF_FLOAT     10
`define PDS_REF_SENSE     11
`define PDS_REF_SPARE     12
`define PDS_REF_DIAG      13
`define PDS_REF_RESET     14'h0400

// =====================================================================
// feedback latch, bits 17..1 of the word stored as latch bits 16..0
`define PDS_FB_W          17
`define PDS_FB_MAIN_HI    16
`define PDS_FB_MAIN_LO    7
`define PDS_FB_SWAL_HI    6
`define PDS_FB_SWAL_LO    2
`define PDS_FB_CLEAR      1
`define PDS_FB_SLEEP      0
`define PDS_FB_RESET      17'h00001

// =====================================================================
// prescaler
`define PDS_PRE_W         6
`define PDS_PRE_LOW_LAST  6'h1f
`define PDS_PRE_HIGH_LAST 6'h20

// =====================================================================
// synchronised pin vector positions
`define PDS_PIN_W         6
`define PDS_PIN_SCLK      0
`define PDS_PIN_SDATA     1
`define PDS_PIN_LOAD      2
`define PDS_PIN_CE        3
`define PDS_PIN_REF       4
`define PDS_PIN_RF        5

`endif

/* rtl/pds_pkg.sv */
// Purpose: types for the synthesizer divider control block
// Assumes: nothing
// Notes:   power mode states only
package pds_pkg;

    // =================================================================
    // power state
    typedef enum logic [1:0] {
        PDS_RUN,
        PDS_SLEEP_WAIT,
        PDS_DOWN,
        PDS_CLEAR
    } pds_power_t;

endpackage : pds_pkg

/* verification/pds_synth_ctrl_monitor.sv */
// Purpose: pin-level checks for the divider control block
// Assumes: pins held stable three clocks or more
// Notes:   bound onto every instance of the block
`include "pds_params.svh"

// ==========================================================
// checker
module pds_synth_ctrl_monitor (
    input wire logic                i_clk,
    input wire logic                i_rst_n,
    input wire logic                i_sclk,
    input wire logic                i_sdata,
    input wire logic                i_load_strobe,
    input wire logic                i_chip_en,
    input wire logic                i_ref_clock_pin,
    input wire logic                i_rf_pin,
    input wire logic                o_cp_out,
    input wire logic                o_cp_oe_n,
    input wire logic                o_pump_up,
    input wire logic                o_pump_dn,
    input wire logic                o_divided_ref_pulse,
    input wire logic                o_divided_rf_pulse,
    input wire logic                o_rf_in_float,
    input wire logic                o_ref_osc_pd,
    input wire logic [`PDS_REF_W-1:0] o_ref_latch,
    input wire logic [`PDS_FB_W-1:0]  o_fb_latch
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);

    sequence ce_low_held;
        !i_chip_en [*4];
    endsequence
    // the strobe is synchronised, so the latch moves a few clocks after the pin
    sequence strobe_seen;
        $past(i_load_strobe, 2);
    endsequence
    sequence down_held;
        o_ref_osc_pd [*2];
    endsequence

    ce_down_a: assert property (ce_low_held |-> o_rf_in_float)
        else $error("chip enable low left the block powered");
    pd_float_a: assert property (down_held |-> o_cp_oe_n)
        else $error("pump driven while powered down");
    pd_pair_a: assert property (o_rf_in_float == o_ref_osc_pd)
        else $error("rf float and oscillator state disagree");
    float_bit_a: assert property (o_ref_latch[10] && !o_ref_latch[13] ##1
        o_ref_latch[10] && !o_ref_latch[13] |-> o_cp_oe_n)
        else $error("pump driven with float bit set");
    pump_lvl_a: assert property (!o_cp_oe_n && !o_ref_latch[13] |->
        o_cp_out == $past(o_pump_up))
        else $error("pump level does not follow command");
    // a divider pulse in the overlap cycle legally restarts that side
    both_clr_a: assert property (o_pump_up && o_pump_dn && !o_divided_ref_pulse && !o_divided_rf_pulse
        |=> !o_pump_up && !o_pump_dn)
        else $error("overlapping commands not cleared");
    ref_pls_a: assert property (o_divided_ref_pulse |=> !o_divided_ref_pulse)
        else $error("reference pulse longer than one clock");
    rf_pls_a: assert property (o_divided_rf_pulse |=> !o_divided_rf_pulse)
        else $error("feedback pulse longer than one clock");
    ref_hold_a: assert property ($changed(o_ref_latch) |-> strobe_seen)
        else $error("reference latch moved without strobe");
    fb_hold_a: assert property ($changed(o_fb_latch) |-> strobe_seen)
        else $error("feedback latch moved without strobe");
endmodule : pds_synth_ctrl_monitor

bind pds_synth_ctrl pds_synth_ctrl_monitor u_mon (
    .i_clk(i_clk), .i_rst_n(i_rst_n), .i_sclk(i_sclk), .i_sdata(i_sdata),
    .i_load_strobe(i_load_strobe), .i_chip_en(i_chip_en), .i_ref_clock_pin(i_ref_clock_pin),
    .i_rf_pin(i_rf_pin), .o_cp_out(o_cp_out), .o_cp_oe_n(o_cp_oe_n), .o_pump_up(o_pump_up),
    .o_pump_dn(o_pump_dn), .o_divided_ref_pulse(o_divided_ref_pulse),
    .o_divided_rf_pulse(o_divided_rf_pulse), .o_rf_in_float(o_rf_in_float),
    .o_ref_osc_pd(o_ref_osc_pd), .o_ref_latch(o_ref_latch), .o_fb_latch(o_fb_latch)
);

/* verification/pds_host_model.sv */
// Purpose: host side of the three-wire serial load port
// Assumes: hold is at least four clocks per pin level
// Notes:   data line shows the inverse of the last bit when idle
// ==========================================================
// host model
module pds_host_model (
    input  wire logic i_clk,
    output logic      o_sclk,
    output logic      o_sdata,
    output logic      o_load_strobe
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        o_sclk = 1'b0;
        o_sdata = 1'b0;
        o_load_strobe = 1'b0;
    end

    task send_word(input logic [17:0] w, input int hold);
        @(posedge i_clk);
        for (int i = 17; i >= 0; i--) begin
            o_sdata <= w[i];
            repeat (hold) @(posedge i_clk);
            o_sclk <= 1'b1;
            repeat (hold) @(posedge i_clk);
            o_sclk <= 1'b0;
        end
        o_load_strobe <= 1'b1;
        repeat (hold) @(posedge i_clk);
        o_load_strobe <= 1'b0;
        o_sdata <= ~w[0];
        repeat (hold) @(posedge i_clk);
    endtask : send_word
endmodule : pds_host_model

/* verification/tb_pds_synth_ctrl.sv */
// Purpose: self-checking bench for the divider control block
// Assumes: host model drives the serial pins
// Notes:   latch notes are queued and matched on each change
`include "pds_params.svh"

// ==========================================================
// bench
module tb_pds_synth_ctrl;
    timeunit 1ns;
    timeprecision 1ps;
    logic i_clk = 0, i_rst_n = 0, i_chip_en = 1, i_ref_clock_pin = 0, i_rf_pin = 0;
    logic sclk, sdata, load, cp_out, cp_oe_n, up, dn, rp, fp, rf_fl, osc_pd;
    logic [13:0] ref_l, e_ref = `PDS_REF_RESET;
    logic [16:0] fb_l, e_fb = `PDS_FB_RESET;
    logic [30:0] notes[$], last_l = {`PDS_REF_RESET, `PDS_FB_RESET};
    logic [31:0] seed = 32'h7454;
    logic [2:0]  ph = 3'h0;
    logic        ref_on = 0, rf_on = 0;
    int errors = 0, total_checks = 0, ref_n = 0, rf_n = 0, ref_at = -1, rf_at = -1;
    int fb_cnt = 0, r_div = 2, n_div = 96;

    pds_host_model host (.i_clk(i_clk), .o_sclk(sclk), .o_sdata(sdata), .o_load_strobe(load));
    pds_synth_ctrl dut (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_sclk(sclk), .i_sdata(sdata),
        .i_load_strobe(load), .i_chip_en(i_chip_en), .i_ref_clock_pin(i_ref_clock_pin),
        .i_rf_pin(i_rf_pin), .o_cp_out(cp_out), .o_cp_oe_n(cp_oe_n), .o_pump_up(up),
        .o_pump_dn(dn), .o_divided_ref_pulse(rp), .o_divided_rf_pulse(fp),
        .o_rf_in_float(rf_fl), .o_ref_osc_pd(osc_pd), .o_ref_latch(ref_l), .o_fb_latch(fb_l));

    initial forever #12.5 i_clk = ~i_clk;

    function logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : rnd

    task check(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            errors++;
            $display("[FAIL] %0t mismatch got %h exp %h", $time, got, exp);
        end
    endtask : check

    task check_latch(input logic [30:0] got);
        if (notes.size() == 0) check(1, 0);
        else check(got, notes.pop_front());
    endtask : check_latch

    task finish_test();
        if (errors == 0 && total_checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : finish_test

    task load_ref(input logic [13:0] v, input int hold);
        logic [31:0] j;
        j = rnd();
        e_ref = v;
        notes.push_back({e_ref, e_fb});
        host.send_word({j[2:0], v, 1'b1}, hold);
    endtask : load_ref

    task load_fb(input logic [16:0] v, input int hold);
        e_fb = v;
        notes.push_back({e_ref, e_fb});
        host.send_word({v, 1'b0}, hold);
    endtask : load_fb

    // every wait is bounded; running out ends the run as a failure
    task wait_hi(input int which);
        for (int n = 0; n < 20000; n++) begin
            @(negedge i_clk);
            if (which == 0 ? up === 1'b1 : which == 1 ? dn === 1'b1 : which == 2 ? fb_cnt >= 3 : rp === 1'b1) return;
        end
        errors++;
        finish_test();
    endtask : wait_hi

    // both pins run at an eighth of the clock, offset so edges never coincide
    always @(posedge i_clk) begin
        ph <= ph + 3'h1;
        if (ph == 3'h0 && ref_on) begin
            i_ref_clock_pin <= 1'b1;
            ref_n++;
        end
        if (ph == 3'h4) i_ref_clock_pin <= 1'b0;
        if (ph == 3'h2 && rf_on) begin
            i_rf_pin <= 1'b1;
            rf_n++;
        end
        if (ph == 3'h6) i_rf_pin <= 1'b0;
    end

    always @(negedge i_clk) if (i_rst_n) begin
        if ({ref_l, fb_l} !== last_l) begin
            last_l = {ref_l, fb_l};
            check_latch(last_l);
        end
        if (rp === 1'b1) begin
            if (ref_at >= 0) check(ref_n - ref_at, r_div);
            ref_at = ref_n;
        end
        if (fp === 1'b1) begin
            if (rf_at >= 0) check(rf_n - rf_at, n_div);
            rf_at = rf_n;
            fb_cnt++;
        end
    end

    initial begin
        repeat (12) @(posedge i_clk);
        i_rst_n <= 1'b1;
        repeat (2) @(posedge i_clk);
        check(rf_fl, 1);
        r_div = 2 + int'(rnd() % 6);
        n_div = 96 + int'(rnd() % 4);
        load_ref({4'b0010, 10'(r_div)}, 4);
        load_fb({10'd3, 5'(n_div - 96), 2'b00}, 7);
        repeat (6) @(posedge i_clk);
        check(rf_fl, 0);
        ref_on <= 1'b1;
        wait_hi(0);
        repeat (2) @(negedge i_clk);
        check(cp_oe_n, 0);
        check(cp_out, 1);
        @(posedge i_clk);
        rf_on <= 1'b1;
        wait_hi(2);
        @(posedge i_clk);
        ref_on <= 1'b0;
        rf_on <= 1'b0;
        load_fb({10'd3, 5'(n_div - 96), 2'b10}, 4);
        check(up | dn, 0);
        load_fb({10'd3, 5'(n_div - 96), 2'b00}, 4);
        load_ref({4'b0000, 10'(r_div)}, 4);
        ref_at = -1;
        ref_on <= 1'b1;
        wait_hi(1);
        repeat (2) @(negedge i_clk);
        check(cp_out, 0);
        check(cp_oe_n, 0);
        @(posedge i_clk);
        ref_on <= 1'b0;
        // diagnostic mode with sense low routes the reference pulse to the pump pin
        load_ref({4'b1001, 10'(r_div)}, 4);
        ref_on <= 1'b1;
        wait_hi(3);
        @(negedge i_clk);
        check(cp_out, 1);
        check(cp_oe_n, 0);
        @(posedge i_clk);
        ref_on <= 1'b0;
        i_chip_en <= 1'b0;
        load_ref({4'b0010, 10'(r_div + 1)}, 4);
        check(rf_fl, 1);
        check(cp_oe_n, 1);
        i_chip_en <= 1'b1;
        load_fb({10'd3, 5'd0, 2'b01}, 4);
        repeat (8) @(posedge i_clk);
        check(osc_pd, 1);
        repeat (10) @(posedge i_clk);
        check(notes.size(), 0);
        finish_test();
    end
endmodule : tb_pds_synth_ctrl
